// *** pstat_regs.svh ***
// constants of the per-port statistics counter block
// assumes inclusion by the block's package and modules only
`ifndef PSTAT_REGS_SVH
`define PSTAT_REGS_SVH

`define PSTAT_NUM_PORTS     10
`define PSTAT_FAST_PORTS    2
`define PSTAT_NUM_CNT       18
`define PSTAT_CNT_WIDTH     32
`define PSTAT_LEN_WIDTH     16

// counter index within a port's set
`define PSTAT_CNT_ADDR_DUP  5'h00
`define PSTAT_CNT_ADDR_CHG  5'h01
`define PSTAT_CNT_BC_RX     5'h02
`define PSTAT_CNT_BC_TX     5'h03
`define PSTAT_CNT_CRS_ERR   5'h04
`define PSTAT_CNT_COLL      5'h05
`define PSTAT_CNT_DEFER     5'h06
`define PSTAT_CNT_EXC_COLL  5'h07
`define PSTAT_CNT_FILTERED  5'h08
`define PSTAT_CNT_GOOD_RX   5'h09
`define PSTAT_CNT_GOOD_TX   5'h0a
`define PSTAT_CNT_LATE_COLL 5'h0b
`define PSTAT_CNT_MC_RX     5'h0c
`define PSTAT_CNT_ALIGN     5'h0d
`define PSTAT_CNT_MC_TX     5'h0e
`define PSTAT_CNT_MULTI     5'h0f
`define PSTAT_CNT_OCTETS    5'h10
`define PSTAT_CNT_OVERSIZE  5'h11

// frame length limits in octets
`define PSTAT_MAX_STD       16'h05ee
`define PSTAT_MAX_LONG      16'h05ff

// timing
`define PSTAT_CLK_MHZ       100
`define PSTAT_RATE10_MBPS   10
`define PSTAT_RATE100_MBPS  100
`define PSTAT_SLOT_BITS     512
`define PSTAT_COLL_MULTI    2'h2

`endif

// *** pstat_pkg.sv ***
// types of the per-port statistics counter block
// assumes pstat_regs.svh sits in the include path
`include "pstat_regs.svh"
`default_nettype none

package pstat_pkg;

  typedef enum logic [3:0] {
    PSTAT_ST_INIT = 4'b0001,
    PSTAT_ST_IDLE = 4'b0010,
    PSTAT_ST_UPD  = 4'b0100,
    PSTAT_ST_HRD  = 4'b1000
  } pstat_state_t;

  typedef logic [4:0] pstat_cidx_t;

endpackage
`default_nettype wire

// *** pstat_cnt_mem.sv ***
// counter storage: one write port, one read port, registered read data
// assumes a single clock; contents are cleared by the owner after reset
`timescale 1ns/1ps
`default_nettype none

module pstat_cnt_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 180,
  parameter int AW    = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rd_data_reg;

  generate
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
      $error("pstat_cnt_mem: depth does not fit address width");
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= '0;
    end else if (rd_en) begin
      rd_data_reg <= mem_q[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule
`default_nettype wire

// *** pstat_top.sv ***
// per-port statistics counters of a ten-port switch
// assumes MAC frame/event strobes on clk_sys; CRS and collision come from PHY pins
//
// Summary of operation
// - count source addresses duplicating a secure address; suspend that port
// - one counter sums secure mismatches and address learns; mismatch suspends port
// - broadcast receive counts good broadcast frames only, never multicast
// - broadcast transmit counts broadcast frames sent, never multicast
// - carrier-sense error counted at most once per transmit attempt
// - ports other than the fast ports count a collision for every jam sent; fast ports never count one, even at 10 Mbit/s
// - count frames whose first transmit attempt was deferred
// - count frames abandoned after excessive collisions
// - count every received frame sent to the discard channel
// - good receive counts all good frames of any destination
// - good transmit counts every completed transmission, bad frames included
// - count collisions seen after 512 bit times of a transmission
// - multicast receive counts good multicast frames, never broadcast
// - fast ports at 100 Mbit/s add receive-error frames to alignment count
// - multicast transmit counts multicast frames, never broadcast
// - count frames sent successfully after two or more collisions
// - accumulate all received octets including bad frames and FCS
// - oversize counts good frames over 1518, or 1535 when long enabled
// - ten-megabit alignment counter records alignment errors only
`include "pstat_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pstat_top
  import pstat_pkg::*;
#(
  parameter int NPORT         = `PSTAT_NUM_PORTS,
  parameter int FAST_PORTS    = `PSTAT_FAST_PORTS,
  parameter int CNT_W         = `PSTAT_CNT_WIDTH,
  parameter int LEN_W         = `PSTAT_LEN_WIDTH,
  parameter int LATE_CYC_10   = `PSTAT_SLOT_BITS * (`PSTAT_CLK_MHZ / `PSTAT_RATE10_MBPS),
  parameter int LATE_CYC_100  = `PSTAT_SLOT_BITS * (`PSTAT_CLK_MHZ / `PSTAT_RATE100_MBPS)
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     long_en,
  input  wire logic [NPORT-1:0]         speed100,
  input  wire logic [NPORT-1:0]         rx_done,
  input  wire logic [NPORT-1:0]         rx_good,
  input  wire logic [NPORT-1:0]         rx_bcast,
  input  wire logic [NPORT-1:0]         rx_mcast,
  input  wire logic [NPORT-1:0]         rx_align_err,
  input  wire logic [NPORT-1:0]         rx_code_err,
  input  wire logic [NPORT*LEN_W-1:0]   rx_len,
  input  wire logic [NPORT-1:0]         rx_discard,
  input  wire logic [NPORT-1:0]         tx_active,
  input  wire logic [NPORT-1:0]         tx_crs,
  input  wire logic [NPORT-1:0]         tx_col,
  input  wire logic [NPORT-1:0]         tx_jam,
  input  wire logic [NPORT-1:0]         tx_defer,
  input  wire logic [NPORT-1:0]         tx_excess,
  input  wire logic [NPORT-1:0]         tx_ok,
  input  wire logic [NPORT-1:0]         tx_bcast,
  input  wire logic [NPORT-1:0]         tx_mcast,
  input  wire logic [NPORT-1:0]         sa_dup,
  input  wire logic [NPORT-1:0]         sa_mismatch,
  input  wire logic [NPORT-1:0]         sa_learn,
  input  wire logic [NPORT-1:0]         suspend_clr,
  input  wire logic                     host_rd_req,
  input  wire logic [3:0]               host_port,
  input  wire logic [4:0]               host_cnt,
  output logic      [NPORT-1:0]         port_suspend,
  output logic                          host_rd_ready,
  output logic                          host_rd_ack,
  output logic      [CNT_W-1:0]         host_rd_data
);

  localparam int NCNT  = `PSTAT_NUM_CNT;
  localparam int DEPTH = NPORT * NCNT;
  localparam int AW    = $clog2(DEPTH);
  localparam int PW    = $clog2(NPORT);
  localparam int OCT_W = LEN_W + 4;
  localparam int BT_W  = $clog2(LATE_CYC_10 + 1);

  localparam logic [AW-1:0]   NCNT_A   = AW'(NCNT);
  localparam logic [AW-1:0]   LAST_A   = AW'(DEPTH - 1);
  localparam logic [PW-1:0]   LAST_P   = PW'(NPORT - 1);
  localparam logic [BT_W-1:0] LATE10_C = BT_W'(LATE_CYC_10);
  localparam logic [BT_W-1:0] LATE100_C = BT_W'(LATE_CYC_100);

  generate
    if (NPORT < 2 || NPORT > 16 || FAST_PORTS > NPORT || CNT_W < OCT_W ||
        LATE_CYC_100 < 1 || LATE_CYC_100 > LATE_CYC_10) begin : g_chk
      $error("pstat_top: parameter values not supported");
    end
  endgenerate

  function automatic pstat_cidx_t low_idx(input logic [NCNT-1:0] m);
    pstat_cidx_t r;
    r = '0;
    for (int i = NCNT - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = pstat_cidx_t'(i);
      end
    end
    return r;
  endfunction

  // scheduler state
  pstat_state_t      state_reg;
  pstat_state_t      state_next;
  logic [AW-1:0]     init_addr_reg;
  logic [PW-1:0]     svc_port_reg;
  logic [PW-1:0]     upd_port_reg;
  pstat_cidx_t       upd_cnt_reg;
  logic              hrd_bad_reg;
  logic              host_ready_reg;
  logic              host_ack_reg;
  logic [CNT_W-1:0]  host_data_reg;

  logic [NPORT*NCNT-1:0]  pend_flat;
  logic [NPORT*OCT_W-1:0] oct_flat;
  logic [NPORT-1:0]       susp_flat;

  // memory hookup
  logic              mem_wr_en;
  logic [AW-1:0]     mem_wr_addr;
  logic [CNT_W-1:0]  mem_wr_data;
  logic              mem_rd_en;
  logic [AW-1:0]     mem_rd_addr;
  logic [CNT_W-1:0]  mem_rd_data;

  wire st_init = (state_reg == PSTAT_ST_INIT);
  wire st_idle = (state_reg == PSTAT_ST_IDLE);
  wire st_upd  = (state_reg == PSTAT_ST_UPD);
  wire st_hrd  = (state_reg == PSTAT_ST_HRD);

  wire [NCNT-1:0]  svc_mask  = pend_flat[svc_port_reg*NCNT +: NCNT];
  wire             svc_any   = |svc_mask;
  wire pstat_cidx_t svc_idx  = low_idx(svc_mask);
  wire             take_host = st_idle & host_rd_req;
  wire             take_upd  = st_idle & ~host_rd_req & svc_any;
  wire             host_bad  = (32'(host_port) >= NPORT) || (32'(host_cnt) >= NCNT);

  wire [AW-1:0] host_addr = AW'(host_port) * NCNT_A + AW'(host_cnt);
  wire [AW-1:0] svc_addr  = AW'(svc_port_reg) * NCNT_A + AW'(svc_idx);
  wire [AW-1:0] upd_addr  = AW'(upd_port_reg) * NCNT_A + AW'(upd_cnt_reg);

  wire              upd_oct  = (upd_cnt_reg == `PSTAT_CNT_OCTETS);
  wire [OCT_W-1:0]  oct_now  = oct_flat[upd_port_reg*OCT_W +: OCT_W];
  wire [CNT_W-1:0]  inc_amt  = upd_oct ? CNT_W'(oct_now) : CNT_W'(1);

  assign mem_rd_en   = take_host | take_upd;
  assign mem_rd_addr = take_host ? host_addr : svc_addr;
  assign mem_wr_en   = st_init | st_upd;
  assign mem_wr_addr = st_init ? init_addr_reg : upd_addr;
  assign mem_wr_data = st_init ? '0 : mem_rd_data + inc_amt;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PSTAT_ST_INIT: begin
        if (init_addr_reg == LAST_A) begin
          state_next = PSTAT_ST_IDLE;
        end
      end
      PSTAT_ST_IDLE: begin
        if (take_host) begin
          state_next = PSTAT_ST_HRD;
        end else if (take_upd) begin
          state_next = PSTAT_ST_UPD;
        end
      end
      PSTAT_ST_UPD: begin
        state_next = PSTAT_ST_IDLE;
      end
      PSTAT_ST_HRD: begin
        state_next = PSTAT_ST_IDLE;
      end
      default: begin
        state_next = PSTAT_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= PSTAT_ST_INIT;
      init_addr_reg  <= '0;
      host_ready_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      init_addr_reg  <= st_init ? init_addr_reg + AW'(1) : init_addr_reg;
      host_ready_reg <= (state_next == PSTAT_ST_IDLE);
    end
  end

  // service pointer stays on a port until its pending set is empty
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      svc_port_reg <= '0;
      upd_port_reg <= '0;
      upd_cnt_reg  <= '0;
    end else if (take_upd) begin
      upd_port_reg <= svc_port_reg;
      upd_cnt_reg  <= svc_idx;
    end else if (st_idle & ~host_rd_req) begin
      svc_port_reg <= (svc_port_reg == LAST_P) ? '0 : svc_port_reg + PW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrd_bad_reg   <= 1'b0;
      host_ack_reg  <= 1'b0;
      host_data_reg <= '0;
    end else begin
      hrd_bad_reg  <= take_host & host_bad;
      host_ack_reg <= st_hrd;
      if (st_hrd) begin
        host_data_reg <= hrd_bad_reg ? '0 : mem_rd_data;
      end
    end
  end

  assign host_rd_ready = host_ready_reg;
  assign host_rd_ack   = host_ack_reg;
  assign host_rd_data  = host_data_reg;
  assign port_suspend  = susp_flat;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      localparam bit IS_FAST = (gp < FAST_PORTS);

      logic              crs_m_reg, crs_s_reg, col_m_reg, col_s_reg, col_d_reg;
      logic              act_d_reg, crs_seen_reg, crs_lost_reg, susp_reg;
      logic [1:0]        ncoll_reg;
      logic [BT_W-1:0]   bt_reg;
      logic [NCNT-1:0]   mask_reg;
      logic [NCNT-1:0]   inc;
      logic [OCT_W-1:0]  oct_reg;

      wire [LEN_W-1:0] len      = rx_len[gp*LEN_W +: LEN_W];
      wire             hs       = IS_FAST && speed100[gp];
      wire [LEN_W-1:0] max_len  = long_en ? LEN_W'(`PSTAT_MAX_LONG) : LEN_W'(`PSTAT_MAX_STD);
      wire             rx_gd    = rx_done[gp] & rx_good[gp];
      wire             col_rise = col_s_reg & ~col_d_reg;
      wire             act_fall = act_d_reg & ~tx_active[gp];
      wire [BT_W-1:0]  late_lim = hs ? LATE100_C : LATE10_C;
      wire             mine     = st_upd && (upd_port_reg == PW'(gp));
      wire [NCNT-1:0]  clr      = mine ? (NCNT'(1) << upd_cnt_reg) : '0;
      wire             oct_take = mine & upd_oct;

      assign inc[`PSTAT_CNT_ADDR_DUP]  = sa_dup[gp];
      assign inc[`PSTAT_CNT_ADDR_CHG]  = sa_mismatch[gp] | sa_learn[gp];
      assign inc[`PSTAT_CNT_BC_RX]     = rx_gd & rx_bcast[gp];
      assign inc[`PSTAT_CNT_BC_TX]     = tx_ok[gp] & tx_bcast[gp];
      assign inc[`PSTAT_CNT_CRS_ERR]   = act_fall & (~crs_seen_reg | crs_lost_reg);
      assign inc[`PSTAT_CNT_COLL]      = !IS_FAST && tx_jam[gp];
      assign inc[`PSTAT_CNT_DEFER]     = tx_defer[gp];
      assign inc[`PSTAT_CNT_EXC_COLL]  = tx_excess[gp];
      assign inc[`PSTAT_CNT_FILTERED]  = rx_discard[gp];
      assign inc[`PSTAT_CNT_GOOD_RX]   = rx_gd;
      assign inc[`PSTAT_CNT_GOOD_TX]   = tx_ok[gp];
      assign inc[`PSTAT_CNT_LATE_COLL] = col_rise & tx_active[gp] & (bt_reg >= late_lim);
      assign inc[`PSTAT_CNT_MC_RX]     = rx_gd & rx_mcast[gp] & ~rx_bcast[gp];
      assign inc[`PSTAT_CNT_ALIGN]     = rx_done[gp] & (rx_align_err[gp] | (hs & rx_code_err[gp]));
      assign inc[`PSTAT_CNT_MC_TX]     = tx_ok[gp] & tx_mcast[gp] & ~tx_bcast[gp];
      assign inc[`PSTAT_CNT_MULTI]     = tx_ok[gp] & (ncoll_reg >= `PSTAT_COLL_MULTI);
      assign inc[`PSTAT_CNT_OCTETS]    = rx_done[gp];
      assign inc[`PSTAT_CNT_OVERSIZE]  = rx_gd & (len > max_len);

      // pin synchronisers and attempt tracking
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          crs_m_reg <= 1'b0;
          crs_s_reg <= 1'b0;
          col_m_reg <= 1'b0;
          col_s_reg <= 1'b0;
          col_d_reg <= 1'b0;
          act_d_reg <= 1'b0;
          bt_reg    <= '0;
        end else begin
          crs_m_reg <= tx_crs[gp];
          crs_s_reg <= crs_m_reg;
          col_m_reg <= tx_col[gp];
          col_s_reg <= col_m_reg;
          col_d_reg <= col_s_reg;
          act_d_reg <= tx_active[gp];
          bt_reg    <= !tx_active[gp] ? '0 : (bt_reg < late_lim ? bt_reg + BT_W'(1) : bt_reg);
        end
      end

      // carrier seen and lost within one attempt
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          crs_seen_reg <= 1'b0;
          crs_lost_reg <= 1'b0;
        end else if (!tx_active[gp]) begin
          crs_seen_reg <= 1'b0;
          crs_lost_reg <= 1'b0;
        end else begin
          crs_seen_reg <= crs_seen_reg | crs_s_reg;
          crs_lost_reg <= crs_lost_reg | (crs_seen_reg & ~crs_s_reg);
        end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          ncoll_reg <= '0;
        end else if (tx_ok[gp] | tx_excess[gp]) begin
          ncoll_reg <= '0;
        end else if (col_rise && ncoll_reg != 2'h3) begin
          ncoll_reg <= ncoll_reg + 2'h1;
        end
      end

      // pending increments; a new event wins over the clear
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mask_reg <= '0;
          oct_reg  <= '0;
          susp_reg <= 1'b0;
        end else begin
          mask_reg <= (mask_reg & ~clr) | inc;
          oct_reg  <= (oct_take ? '0 : oct_reg) + (rx_done[gp] ? OCT_W'(len) : '0);
          susp_reg <= (susp_reg & ~suspend_clr[gp]) | sa_dup[gp] | sa_mismatch[gp];
        end
      end

      assign pend_flat[gp*NCNT +: NCNT]   = mask_reg;
      assign oct_flat[gp*OCT_W +: OCT_W]  = oct_reg;
      assign susp_flat[gp]                = susp_reg;
    end
  endgenerate

  pstat_cnt_mem #(
    .DW    (CNT_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_en   (mem_rd_en),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data)
  );

endmodule
`default_nettype wire

// *** pstat_asserts.sv ***
// concurrent checks on the host read port and the port suspend outputs
// assumes binding into pstat_top; single clock domain clk_sys
`timescale 1ns/1ps
`default_nettype none

module pstat_asserts #(
  parameter int NPORT = 10,
  parameter int CNT_W = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             host_rd_req,
  input  wire logic [3:0]       host_port,
  input  wire logic [4:0]       host_cnt,
  input  wire logic             host_rd_ready,
  input  wire logic             host_rd_ack,
  input  wire logic [CNT_W-1:0] host_rd_data,
  input  wire logic [NPORT-1:0] sa_dup,
  input  wire logic [NPORT-1:0] sa_mismatch,
  input  wire logic [NPORT-1:0] suspend_clr,
  input  wire logic [NPORT-1:0] port_suspend
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_taken;
    host_rd_req && host_rd_ready;
  endsequence

  sequence s_answer;
    !host_rd_ready && !host_rd_ack ##1 host_rd_ready && host_rd_ack;
  endsequence

  AST_READ_WALK: assert property (s_taken |=> s_answer)
    else $error("read not answered in the second cycle");
  AST_ACK_CAUSE: assert property (host_rd_ack |->
    $past(host_rd_req, 2) && $past(host_rd_ready, 2))
    else $error("acknowledge without a request");
  AST_ACK_PULSE: assert property (host_rd_ack |=> !host_rd_ack)
    else $error("acknowledge longer than one cycle");
  AST_DATA_HOLD: assert property (!host_rd_ack |-> $stable(host_rd_data))
    else $error("read data changed without acknowledge");
  AST_UNMAPPED: assert property (s_taken ##0
    (host_port >= NPORT || host_cnt >= 5'h12) |-> ##2 host_rd_data == '0)
    else $error("unmapped read returned nonzero data");
  AST_SUSP_DUP: assert property (|sa_dup |=>
    (port_suspend & $past(sa_dup)) == $past(sa_dup))
    else $error("duplicate address did not suspend port");
  AST_SUSP_MIS: assert property (|sa_mismatch |=>
    (port_suspend & $past(sa_mismatch)) == $past(sa_mismatch))
    else $error("address mismatch did not suspend port");
  AST_SUSP_CAUSE: assert property (1'b1 |=>
    (port_suspend & ~$past(port_suspend) & ~$past(sa_dup) & ~$past(sa_mismatch)) == '0)
    else $error("port suspended without address event");
  AST_SUSP_CLR: assert property (|suspend_clr |=>
    (port_suspend & $past(suspend_clr) & ~$past(sa_dup) & ~$past(sa_mismatch)) == '0)
    else $error("suspend clear ignored");
endmodule

bind pstat_top pstat_asserts #(.NPORT(NPORT), .CNT_W(CNT_W)) pstat_asserts_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .host_rd_req(host_rd_req), .host_port(host_port),
  .host_cnt(host_cnt), .host_rd_ready(host_rd_ready), .host_rd_ack(host_rd_ack),
  .host_rd_data(host_rd_data), .sa_dup(sa_dup), .sa_mismatch(sa_mismatch),
  .suspend_clr(suspend_clr), .port_suspend(port_suspend)
);
`default_nettype wire

// *** pstat_mac_model.sv ***
// event source model: MAC and PHY side of all ten ports
// assumes a 100 MHz clk_sys; every signal changes at the falling edge
`timescale 1ns/1ps
`default_nettype none

module pstat_mac_model (
  input  wire logic         clk_sys,
  output logic      [9:0]   rx_done,
  output logic      [9:0]   rx_good,
  output logic      [9:0]   rx_bcast,
  output logic      [9:0]   rx_mcast,
  output logic      [9:0]   rx_align_err,
  output logic      [9:0]   rx_code_err,
  output logic      [159:0] rx_len,
  output logic      [9:0]   rx_discard,
  output logic      [9:0]   tx_active,
  output logic      [9:0]   tx_crs,
  output logic      [9:0]   tx_col,
  output logic      [9:0]   tx_jam,
  output logic      [9:0]   tx_defer,
  output logic      [9:0]   tx_excess,
  output logic      [9:0]   tx_ok,
  output logic      [9:0]   tx_bcast,
  output logic      [9:0]   tx_mcast,
  output logic      [9:0]   sa_dup,
  output logic      [9:0]   sa_mismatch,
  output logic      [9:0]   sa_learn,
  output logic      [9:0]   suspend_clr
);
  initial begin
    {rx_done, rx_good, rx_bcast, rx_mcast, rx_align_err, rx_code_err, rx_len} = '0;
    {rx_discard, tx_active, tx_crs, tx_col, tx_jam, tx_defer, tx_excess} = '0;
    {tx_ok, tx_bcast, tx_mcast, sa_dup, sa_mismatch, sa_learn, suspend_clr} = '0;
  end

  // q = {discard, code err, align err, mcast, bcast, good}; qualifiers garbled after
  task automatic rx_frame(input int p, input logic [5:0] q, input logic [15:0] len);
    @(negedge clk_sys);
    {rx_discard[p], rx_code_err[p], rx_align_err[p], rx_mcast[p], rx_bcast[p], rx_good[p]} = q;
    rx_done[p] = 1'b1;
    rx_len[p*16 +: 16] = len;
    @(negedge clk_sys);
    {rx_discard[p], rx_done[p]} = 2'h0;
    {rx_code_err[p], rx_align_err[p], rx_mcast[p], rx_bcast[p], rx_good[p]} = ~q[4:0];
    rx_len[p*16 +: 16] = ~len;
  endtask

  // f = {mcast, bcast, ok, late collision, deferred}; crsm 0 ok, 1 never, 2 lost
  task automatic tx_try(input int p, input int crsm, input int nc, input int thr,
                        input logic [4:0] f);
    @(negedge clk_sys);
    tx_defer[p]  = f[0];
    tx_active[p] = 1'b1;
    tx_crs[p]    = (crsm != 1);
    for (int t = 0; t < thr + 20; t++) begin
      @(negedge clk_sys);
      tx_defer[p] = 1'b0;
      tx_jam[p]   = (nc > 0 && t == 2);
      tx_col[p]   = (nc > 0 && t inside {[2:3]}) || (nc > 1 && t inside {[8:9]})
                    || (f[1] && t >= thr + 8 && t < thr + 10);
      if (crsm == 2 && t > 4 && t < 16) tx_crs[p] = t[0];
    end
    @(negedge clk_sys);
    {tx_active[p], tx_crs[p], tx_col[p], tx_jam[p]} = 4'h0;
    {tx_mcast[p], tx_bcast[p], tx_ok[p], tx_excess[p]} = {f[4:2], !f[2]};
    @(negedge clk_sys);
    {tx_mcast[p], tx_bcast[p], tx_ok[p], tx_excess[p]} = {~f[4:3], 2'h0};
  endtask

  // k: 0 duplicate, 1 mismatch, 2 learn, 3 suspend clear
  task automatic sa_ev(input int p, input int k);
    @(negedge clk_sys);
    {sa_dup[p], sa_mismatch[p], sa_learn[p], suspend_clr[p]} = {k == 0, k == 1, k == 2, k == 3};
    @(negedge clk_sys);
    {sa_dup[p], sa_mismatch[p], sa_learn[p], suspend_clr[p]} = 4'h0;
  endtask
endmodule
`default_nettype wire

// *** tb_port_statistics_counters.sv ***
// self-checking bench of the per-port statistics counters
// assumes the event model and the checker are compiled before it
`include "pstat_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_port_statistics_counters;
  localparam int LATE10  = 80;
  localparam int LATE100 = 30;
  logic              clk_sys = 1'b0;
  logic              rst_n;
  logic              long_en;
  logic [9:0]        speed100;
  logic              host_rd_req;
  logic [3:0]        host_port;
  logic [4:0]        host_cnt;
  wire logic [9:0]   rx_done, rx_good, rx_bcast, rx_mcast, rx_align_err, rx_code_err;
  wire logic [159:0] rx_len;
  wire logic [9:0]   rx_discard, tx_active, tx_crs, tx_col, tx_jam, tx_defer, tx_excess;
  wire logic [9:0]   tx_ok, tx_bcast, tx_mcast, sa_dup, sa_mismatch, sa_learn, suspend_clr;
  wire logic [9:0]   port_suspend;
  wire logic         host_rd_ready;
  wire logic         host_rd_ack;
  wire logic [31:0]  host_rd_data;
  int unsigned       exp_cnt [10][18];
  int                failures = 0;
  int                n_checks = 0;

  always #5 clk_sys = ~clk_sys;

  pstat_top #(.LATE_CYC_10(LATE10), .LATE_CYC_100(LATE100)) pstat_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .long_en(long_en), .speed100(speed100),
    .rx_done(rx_done), .rx_good(rx_good), .rx_bcast(rx_bcast), .rx_mcast(rx_mcast),
    .rx_align_err(rx_align_err), .rx_code_err(rx_code_err), .rx_len(rx_len),
    .rx_discard(rx_discard), .tx_active(tx_active), .tx_crs(tx_crs), .tx_col(tx_col),
    .tx_jam(tx_jam), .tx_defer(tx_defer), .tx_excess(tx_excess), .tx_ok(tx_ok),
    .tx_bcast(tx_bcast), .tx_mcast(tx_mcast), .sa_dup(sa_dup), .sa_mismatch(sa_mismatch),
    .sa_learn(sa_learn), .suspend_clr(suspend_clr), .host_rd_req(host_rd_req),
    .host_port(host_port), .host_cnt(host_cnt), .port_suspend(port_suspend),
    .host_rd_ready(host_rd_ready), .host_rd_ack(host_rd_ack), .host_rd_data(host_rd_data)
  );

  pstat_mac_model pstat_mac_model_inst (
    .clk_sys(clk_sys), .rx_done(rx_done), .rx_good(rx_good), .rx_bcast(rx_bcast),
    .rx_mcast(rx_mcast), .rx_align_err(rx_align_err), .rx_code_err(rx_code_err),
    .rx_len(rx_len), .rx_discard(rx_discard), .tx_active(tx_active), .tx_crs(tx_crs),
    .tx_col(tx_col), .tx_jam(tx_jam), .tx_defer(tx_defer), .tx_excess(tx_excess),
    .tx_ok(tx_ok), .tx_bcast(tx_bcast), .tx_mcast(tx_mcast), .sa_dup(sa_dup),
    .sa_mismatch(sa_mismatch), .sa_learn(sa_learn), .suspend_clr(suspend_clr)
  );

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] w);
    n_checks++;
    if (seen !== w) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, w, seen);
    end
  endtask

  task automatic host_read(input int p, input int c, output logic [31:0] d);
    int i;
    i = 0;
    d = 32'h0;
    while (host_rd_ready !== 1'b1 && i < 2000) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 2000) begin
      failures++;
      print_verdict();
    end else begin
      {host_rd_req, host_port, host_cnt} = {1'b1, 4'(p), 5'(c)};
      @(negedge clk_sys);
      host_rd_req = 1'b0;
      @(negedge clk_sys);
      check("read ack", 32'(host_rd_ack), 32'h1);
      d = host_rd_data;
    end
  endtask

  // every counter of every port plus one unmapped port and index
  task automatic check_all();
    logic [31:0] d;
    logic [31:0] w;
    string       s;
    for (int i = 0; i < 209; i++) begin
      host_read(i / 19, i % 19, d);
      w = (i / 19 < 10 && i % 19 < 18) ? exp_cnt[i / 19][i % 19] : 32'h0;
      s = $sformatf("port %0d counter %0d", i / 19, i % 19);
      check(s, d, w);
    end
  endtask

  task automatic rx_ev(input int p);
    logic [5:0]  q;
    logic [15:0] lim;
    logic [15:0] len;
    q   = 6'($urandom);
    lim = long_en ? `PSTAT_MAX_LONG : `PSTAT_MAX_STD;
    len = ($urandom % 2) ? lim + 16'($urandom % 2) : 16'h0040 + 16'($urandom % 1500);
    pstat_mac_model_inst.rx_frame(p, q, len);
    if (q[0]) exp_cnt[p][`PSTAT_CNT_GOOD_RX]++;
    if (q[0] && q[1]) exp_cnt[p][`PSTAT_CNT_BC_RX]++;
    if (q[0] && q[2] && !q[1]) exp_cnt[p][`PSTAT_CNT_MC_RX]++;
    if (q[3] || (q[4] && p < 2 && speed100[p])) exp_cnt[p][`PSTAT_CNT_ALIGN]++;
    if (q[5]) exp_cnt[p][`PSTAT_CNT_FILTERED]++;
    if (q[0] && len > lim) exp_cnt[p][`PSTAT_CNT_OVERSIZE]++;
    exp_cnt[p][`PSTAT_CNT_OCTETS] += len;
  endtask

  task automatic tx_ev(input int p);
    int         crsm;
    int         nc;
    int         thr;
    logic [4:0] f;
    crsm = $urandom % 3;
    nc   = $urandom % 3;
    f    = 5'($urandom);
    thr  = (p < 2 && speed100[p]) ? LATE100 : LATE10;
    pstat_mac_model_inst.tx_try(p, crsm, nc, thr, f);
    if (f[0]) exp_cnt[p][`PSTAT_CNT_DEFER]++;
    if (crsm != 0) exp_cnt[p][`PSTAT_CNT_CRS_ERR]++;
    if (p >= 2 && nc > 0) exp_cnt[p][`PSTAT_CNT_COLL]++;
    if (f[1]) exp_cnt[p][`PSTAT_CNT_LATE_COLL]++;
    if (!f[2]) exp_cnt[p][`PSTAT_CNT_EXC_COLL]++;
    if (f[2]) exp_cnt[p][`PSTAT_CNT_GOOD_TX]++;
    if (f[2] && f[3]) exp_cnt[p][`PSTAT_CNT_BC_TX]++;
    if (f[2] && f[4] && !f[3]) exp_cnt[p][`PSTAT_CNT_MC_TX]++;
    if (f[2] && nc + f[1] >= 2) exp_cnt[p][`PSTAT_CNT_MULTI]++;
  endtask

  initial begin
    int k;
    {rst_n, long_en, speed100, host_rd_req, host_port, host_cnt} = '0;
    k = $urandom(32'h6ed280bf);
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    check_all();
    for (int r = 0; r < 4; r++) begin
      long_en  = r[0];
      speed100 = 10'($urandom);
      for (int p = 0; p < 10; p++) rx_ev(p);
      for (int p = 0; p < 10; p++) tx_ev(p);
      for (int p = 0; p < 10; p++) begin
        k = $urandom % 3;
        pstat_mac_model_inst.sa_ev(p, k);
        if (k == 0) exp_cnt[p][`PSTAT_CNT_ADDR_DUP]++;
        else exp_cnt[p][`PSTAT_CNT_ADDR_CHG]++;
        check("suspend set", 32'(port_suspend[p]), 32'(k != 2));
        pstat_mac_model_inst.sa_ev(p, 3);
        check("suspend clear", 32'(port_suspend[p]), 32'h0);
      end
      repeat (600) @(negedge clk_sys);
      check_all();
    end
    print_verdict();
  end
endmodule
`default_nettype wire
